//--- ioc_regs.vh
`ifndef IOC_REGS_VH
`define IOC_REGS_VH

// Register byte addresses
`define IOC_ADDR_CTRL 4'h0
`define IOC_ADDR_STATUS 4'h4
`define IOC_ADDR_W 4

// Control register fields
`define IOC_CTRL_CAPTURE_EN 0
`define IOC_CTRL_VARIANT 1
`define IOC_CTRL_INV_OUT_CLK 2
`define IOC_CTRL_INV_IN_CLK 3
`define IOC_CTRL_OUT_INVERT 4
`define IOC_CTRL_OUT_REGISTERED 5
`define IOC_CTRL_TRI_INVERT 6
`define IOC_CTRL_INIT_SET 7
`define IOC_CTRL_DELAY_LO 8
`define IOC_CTRL_DELAY_HI 9
`define IOC_CTRL_TRI_CONNECTED 10
`define IOC_CTRL_CE_CONNECTED 11
`define IOC_CTRL_SOFT_GSR 12
`define IOC_CTRL_W 13
`define IOC_CTRL_RESET 13'h0000

// Input delay selection codes
`define IOC_DELAY_AUTO 2'h0
`define IOC_DELAY_MEDIUM 2'h1
`define IOC_DELAY_FULL 2'h2
`define IOC_DELAY_NONE 2'h3

// Status register fields
`define IOC_STAT_PAD 0
`define IOC_STAT_CAPTURE 1
`define IOC_STAT_INPUT 2
`define IOC_STAT_OUTREG 3
`define IOC_STAT_OE_N 4
`define IOC_STAT_W 5

// Bus responses
`define IOC_RESP_OKAY 2'h0
`define IOC_RESP_SLVERR 2'h2

`endif

//--- ioc_io_cell.v
`timescale 1ns/100ps
// Functional notes
// - Early capture latch is timed by the output-side clock, not the input clock.
// - Capture latch data passes on to the input flop or latch.
// - Variant one: low-transparent capture latch feeding rising-edge input flop.
// - Variant two: low-transparent capture latch feeding high-transparent input latch.
// - Each clock into the capture variants can be inverted inside the cell.
// - With capture latch in use, default input delay becomes medium.
// - Output optionally inverted, then direct to pad or through output register.
// - Three-state control high, after optional inversion, forces the pad driver off regardless of data.
// - Output data and three-state polarity configurable independently.
// - Power-up or global set/reset loads output register with its initial value.
// - Output register loads on rising edge only with clock enable high.
// - Unconnected three-state control reads as low.
// - Unconnected output clock enable reads as high.
`include "ioc_regs.vh"

module ioc_io_cell (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire pad_in,
	output reg pad_out,
	output reg pad_oe_n,
	input wire out_clk,
	input wire in_clk,
	input wire out_data,
	input wire out_ce,
	input wire tri_ctl,
	input wire global_set_reset,
	output reg in_data
);

////////////////////////////////////////////////////////////////////////////////
// Registers and state

reg [`IOC_CTRL_W-1:0] ctrl;
reg aw_got;
reg w_got;
reg [`IOC_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg pad_d1;
reg pad_d2;
reg early_capture_latch;
reg in_q;
reg in_clk_prev;
reg out_clk_prev;
reg out_q;

wire capture_en = ctrl[`IOC_CTRL_CAPTURE_EN];
wire [1:0] delay_field = ctrl[`IOC_CTRL_DELAY_HI:`IOC_CTRL_DELAY_LO];

////////////////////////////////////////////////////////////////////////////////
// Input path

reg [1:0] next_delay;
reg next_pad;
wire eff_out_clk = out_clk ^ ctrl[`IOC_CTRL_INV_OUT_CLK];
wire eff_in_clk = in_clk ^ ctrl[`IOC_CTRL_INV_IN_CLK];
wire in_src = capture_en ? early_capture_latch : next_pad;
wire in_rise = eff_in_clk & ~in_clk_prev;

always @* begin
	next_delay = delay_field;
	if (delay_field == `IOC_DELAY_AUTO) begin
		next_delay = capture_en ? `IOC_DELAY_MEDIUM : `IOC_DELAY_NONE;
	end
	case (next_delay)
		`IOC_DELAY_MEDIUM: next_pad = pad_d1;
		`IOC_DELAY_FULL: next_pad = pad_d2;
		default: next_pad = pad_in;
	endcase
end

reg next_capture;
reg next_in_q;

// Capture latch follows the sampled level of its clock; the input element follows the level (latch variant) or a sampled rising edge (flop variant)
always @* begin
	next_capture = early_capture_latch;
	if (!eff_out_clk) begin
		next_capture = next_pad;
	end
	next_in_q = in_q;
	if (ctrl[`IOC_CTRL_VARIANT]) begin
		if (eff_in_clk) begin
			next_in_q = in_src;
		end
	end else begin
		if (in_rise) begin
			next_in_q = in_src;
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		pad_d1 <= 1'b0;
		pad_d2 <= 1'b0;
		early_capture_latch <= 1'b0;
		in_q <= 1'b0;
		in_clk_prev <= 1'b0;
		in_data <= 1'b0;
	end else begin
		pad_d1 <= pad_in;
		pad_d2 <= pad_d1;
		in_clk_prev <= eff_in_clk;
		early_capture_latch <= next_capture;
		in_q <= next_in_q;
		in_data <= in_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Output path

wire eff_data = out_data ^ ctrl[`IOC_CTRL_OUT_INVERT];
wire eff_ce = ctrl[`IOC_CTRL_CE_CONNECTED] ? out_ce : 1'b1;
wire eff_tri_raw = ctrl[`IOC_CTRL_TRI_CONNECTED] ? tri_ctl : 1'b0;
wire eff_tri = eff_tri_raw ^ ctrl[`IOC_CTRL_TRI_INVERT];
wire out_rise = eff_out_clk & ~out_clk_prev;
wire gsr_active = global_set_reset | ctrl[`IOC_CTRL_SOFT_GSR];

reg next_out_q;
reg next_pad_out;
reg next_pad_oe_n;

always @* begin
	next_out_q = out_q;
	if (gsr_active) begin
		next_out_q = ctrl[`IOC_CTRL_INIT_SET];
	end else if (out_rise && eff_ce) begin
		next_out_q = eff_data;
	end
	if (ctrl[`IOC_CTRL_OUT_REGISTERED]) begin
		next_pad_out = out_q;
	end else begin
		next_pad_out = eff_data;
	end
	next_pad_oe_n = eff_tri;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		out_q <= 1'b0;
		out_clk_prev <= 1'b0;
		pad_out <= 1'b0;
		pad_oe_n <= 1'b0;
	end else begin
		out_clk_prev <= eff_out_clk;
		out_q <= next_out_q;
		pad_out <= next_pad_out;
		pad_oe_n <= next_pad_oe_n;
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel

wire aw_hit_ctrl = (aw_addr == `IOC_ADDR_CTRL);
wire aw_hit_stat = (aw_addr == `IOC_ADDR_STATUS);
reg [31:0] next_ctrl_word;

always @* begin
	next_ctrl_word = {{(32-`IOC_CTRL_W){1'b0}}, ctrl};
	if (w_strb[0]) begin
		next_ctrl_word[7:0] = w_data[7:0];
	end
	if (w_strb[1]) begin
		next_ctrl_word[15:8] = w_data[15:8];
	end
end

localparam WR_WAIT = 2'h0;
localparam WR_COMMIT = 2'h1;
localparam WR_RESP = 2'h2;

wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
reg [1:0] wr_state;
reg [1:0] next_wr_state;
reg next_aw_got;
reg next_w_got;
reg next_awready;
reg next_wready;
reg next_bvalid;
reg [1:0] next_bresp;
reg next_ctrl_load;

// Address and data may arrive in either order; the response waits for both
always @* begin
	next_wr_state = wr_state;
	next_aw_got = aw_got;
	next_w_got = w_got;
	next_awready = s_axi_awready;
	next_wready = s_axi_wready;
	next_bvalid = s_axi_bvalid;
	next_bresp = s_axi_bresp;
	next_ctrl_load = 1'b0;
	case (wr_state)
		WR_WAIT: begin
			if (aw_take) begin
				next_aw_got = 1'b1;
				next_awready = 1'b0;
			end
			if (w_take) begin
				next_w_got = 1'b1;
				next_wready = 1'b0;
			end
			if ((aw_got || aw_take) && (w_got || w_take)) begin
				next_wr_state = WR_COMMIT;
			end
		end
		WR_COMMIT: begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_wr_state = WR_RESP;
			if (aw_hit_ctrl) begin
				next_ctrl_load = 1'b1;
				next_bresp = `IOC_RESP_OKAY;
			end else if (aw_hit_stat) begin
				next_bresp = `IOC_RESP_OKAY;
			end else begin
				next_bresp = `IOC_RESP_SLVERR;
			end
		end
		WR_RESP: begin
			if (s_axi_bready) begin
				next_bvalid = 1'b0;
				next_awready = 1'b1;
				next_wready = 1'b1;
				next_wr_state = WR_WAIT;
			end
		end
		default: begin
			next_wr_state = WR_WAIT;
		end
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		wr_state <= WR_WAIT;
		ctrl <= `IOC_CTRL_RESET;
		aw_got <= 1'b0;
		w_got <= 1'b0;
		aw_addr <= {`IOC_ADDR_W{1'b0}};
		w_data <= 32'h00000000;
		w_strb <= 4'h0;
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `IOC_RESP_OKAY;
	end else begin
		wr_state <= next_wr_state;
		aw_got <= next_aw_got;
		w_got <= next_w_got;
		s_axi_awready <= next_awready;
		s_axi_wready <= next_wready;
		s_axi_bvalid <= next_bvalid;
		s_axi_bresp <= next_bresp;
		if (aw_take) begin
			aw_addr <= s_axi_awaddr[`IOC_ADDR_W-1:0];
		end
		if (w_take) begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (next_ctrl_load) begin
			ctrl <= next_ctrl_word[`IOC_CTRL_W-1:0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel

reg [`IOC_STAT_W-1:0] status;

always @* begin
	status = {`IOC_STAT_W{1'b0}};
	status[`IOC_STAT_PAD] = next_pad;
	status[`IOC_STAT_CAPTURE] = early_capture_latch;
	status[`IOC_STAT_INPUT] = in_q;
	status[`IOC_STAT_OUTREG] = out_q;
	status[`IOC_STAT_OE_N] = pad_oe_n;
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `IOC_RESP_OKAY;
	end else begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `IOC_RESP_OKAY;
			case (s_axi_araddr[`IOC_ADDR_W-1:0])
				`IOC_ADDR_CTRL: s_axi_rdata <= {{(32-`IOC_CTRL_W){1'b0}}, ctrl};
				`IOC_ADDR_STATUS: s_axi_rdata <= {{(32-`IOC_STAT_W){1'b0}}, status};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `IOC_RESP_SLVERR;
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule // ioc_io_cell

//--- ioc_io_cell_asserts.sv
`timescale 1ns/100ps
module ioc_io_cell_asserts (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire pad_out,
	input wire pad_oe_n,
	input wire out_clk,
	input wire out_data,
	input wire out_ce,
	input wire tri_ctl,
	input wire global_set_reset
);
	logic [12:0] ctrl;
	wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire idle = s_axi_awready && !s_axi_bvalid;
	wire qm = idle && ctrl[5] && !ctrl[12] && !global_set_reset;
	// Mirror of the control word, valid only while each write hands over address and data in the same cycle
	always @(posedge aclk)
		if (!aresetn)
			ctrl <= 13'h0000;
		else if (wr && s_axi_awaddr[3:0] == 4'h0)
			ctrl <= s_axi_wdata[12:0];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_tri; idle && ctrl[10] |=> pad_oe_n == ($past(tri_ctl) ^ $past(ctrl[6])); endproperty
	a_tri: assert property (p_tri) else $error("tri level");
	property p_tri_def; idle && !ctrl[10] && !ctrl[6] |=> !pad_oe_n; endproperty
	a_tri_def: assert property (p_tri_def) else $error("tri default");
	property p_dir; idle && !ctrl[5] |=> pad_out == ($past(out_data) ^ $past(ctrl[4])); endproperty
	a_dir: assert property (p_dir) else $error("direct out");
	property p_load; (!out_clk ##1 out_clk && qm && !ctrl[4] && !ctrl[2] && !ctrl[11])
		|=> ##1 pad_out == $past(out_data, 2); endproperty
	a_load: assert property (p_load) else $error("reg load");
	property p_hold; (qm && ctrl[11] && !out_ce) [*2] |=> $stable(pad_out); endproperty
	a_hold: assert property (p_hold) else $error("reg hold");
	property p_gsr; (idle && ctrl[5] && global_set_reset) [*2] |=> pad_out == ctrl[7]; endproperty
	a_gsr: assert property (p_gsr) else $error("init value");
	property p_b; wr |=> ##1 s_axi_bvalid; endproperty
	a_b: assert property (p_b) else $error("write resp");
	property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_r: assert property (p_r) else $error("read resp");
	c_load: cover property (!out_clk ##1 out_clk && qm);
	c_gsr: cover property ((idle && ctrl[5] && global_set_reset) [*2]);
	c_tri: cover property (idle && ctrl[10] && tri_ctl);
endmodule // ioc_io_cell_asserts

//--- ioc_pad_model.sv
`timescale 1ns/100ps
module ioc_pad_model (
	input wire aclk,
	input wire pad_out,
	input wire pad_oe_n,
	input wire ext_val,
	output logic pad_in
);
	// While the cell drives, the pad shows its data; released, the board level
	assign pad_in = !pad_oe_n ? pad_out : ext_val;
endmodule // ioc_pad_model

//--- tb_ioc_io_cell.sv
`timescale 1ns/100ps
module tb_ioc_io_cell;
	logic aclk = 1'h0, aresetn = 1'h0, pad_in, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pad_out, pad_oe_n, in_data, out_clk = 1'h0, in_clk = 1'h0, out_data = 1'h0;
	logic out_ce = 1'h0, tri_ctl = 1'h0, global_set_reset = 1'h0, ext_val = 1'h0;
	bit ta, tw, tr, tb;
	int miscompares = 0, comparisons = 0, cyc = 0;
	ioc_io_cell ioc_io_cell_i (.*);
	ioc_pad_model ioc_pad_model_i (.aclk, .pad_out, .pad_oe_n, .ext_val, .pad_in);
	initial forever #2.5 aclk = !aclk;
	task end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cmp(input string n, input [31:0] e, input [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task acc(input bit w, input [3:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= {28'h0, a};
		s_axi_araddr <= {28'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tr = s_axi_arready;
			tb = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
			rs = w ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tr) s_axi_arvalid <= 1'h0;
			if (tb) s_axi_bready <= 1'h0;
			if (tb) s_axi_rready <= 1'h0;
		end while (!tb);
	endtask
	// Bit 0 toggles the output clock, bit 1 the input clock
	task tog(input bit [1:0] o);
		@(posedge aclk);
		if (o[0]) out_clk <= !out_clk;
		if (o[1]) in_clk <= !in_clk;
		repeat (4) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			end_sim;
		end
	end
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		acc(1'h0, 4'h0, 32'h0);
		cmp("ctrl", 32'h0, rd);
		acc(1'h1, 4'h0, 32'h1fff);
		acc(1'h0, 4'h0, 32'h0);
		cmp("ctrl", 32'h1fff, rd);
		acc(1'h1, 4'h8, 32'h0);
		cmp("bresp", 32'h2, rs);
		acc(1'h0, 4'h8, 32'h0);
		cmp("rresp", 32'h2, rs);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			acc(1'h1, 4'h0, i[1] ? 32'h450 : 32'h400);
			tri_ctl <= i[0];
			out_data <= i[0];
			tog(2'h0);
			cmp("pad_oe_n", i[0] ^ i[1], pad_oe_n);
			cmp("pad_out", i[0] ^ i[1], pad_out);
		end
		acc(1'h1, 4'h0, 32'h0);
		tog(2'h0);
		cmp("pad_oe_n", 32'h0, pad_oe_n);
		acc(1'h1, 4'h0, 32'h20);
		out_data <= 1'h0;
		tog(2'h1);
		tog(2'h1);
		cmp("pad_out", 32'h0, pad_out);
		out_data <= 1'h1;
		tog(2'h1);
		tog(2'h1);
		cmp("pad_out", 32'h1, pad_out);
		acc(1'h1, 4'h0, 32'h820);
		out_data <= 1'h0;
		tog(2'h1);
		tog(2'h1);
		cmp("pad_out", 32'h1, pad_out);
		out_ce <= 1'h1;
		tog(2'h1);
		tog(2'h1);
		cmp("pad_out", 32'h0, pad_out);
		acc(1'h1, 4'h0, 32'h8a0);
		global_set_reset <= 1'h1;
		tog(2'h1);
		cmp("pad_out", 32'h1, pad_out);
		global_set_reset <= 1'h0;
		tog(2'h1);
		tog(2'h1);
		cmp("pad_out", 32'h0, pad_out);
		$display("test output done");
		tog(2'h1);
		acc(1'h1, 4'h0, 32'h401);
		ext_val <= 1'h1;
		tog(2'h0);
		tog(2'h2);
		tog(2'h2);
		cmp("in_data", 32'h1, in_data);
		tog(2'h1);
		ext_val <= 1'h0;
		tog(2'h0);
		tog(2'h2);
		tog(2'h2);
		cmp("in_data", 32'h1, in_data);
		tog(2'h1);
		tog(2'h3);
		tog(2'h3);
		cmp("in_data", 32'h0, in_data);
		acc(1'h1, 4'h0, 32'h407);
		ext_val <= 1'h1;
		tog(2'h2);
		cmp("in_data", 32'h0, in_data);
		tog(2'h1);
		cmp("in_data", 32'h1, in_data);
		acc(1'h0, 4'h4, 32'h0);
		cmp("status", 32'h7, {29'h0, rd[2:0]});
		acc(1'h1, 4'h0, 32'h40f);
		ext_val <= 1'h0;
		tog(2'h0);
		cmp("in_data", 32'h1, in_data);
		tog(2'h2);
		cmp("in_data", 32'h0, in_data);
		$display("test input done");
		end_sim;
	end
endmodule // tb_ioc_io_cell
bind ioc_io_cell ioc_io_cell_asserts ioc_io_cell_asserts_i (.*);
